// File: src/ic_icache.sv
`timescale 1ns/1ps
`include "ic_defines.svh"
// Function
// - direct mapped: 32 lines of 16 bytes, 32 tags, 128 data words
// - tags indexed by address 8:4, data words by address 8:2, in parallel
// - tag compared with address 31:9 and line valid; hit answers next cycle
// - one valid bit per line, so only whole lines enter the array
// - fill buffer checked every fetch; per-longword valid bits give early hits
// - on a miss the fetch is released while the line streams in
// - fetch mapped to on-chip SRAM: cache output dropped, no external fetch
// - attributes from region zero, else region one, else control defaults
// - control bit 24 clears all tags, one per cycle, 32 cycles
// - fetches held off while whole-cache invalidation runs
// - line invalidate clears tag at address 8:4 unless bit 28 set
// - reset clears control word; tag array contents left untouched
// - enabled, cacheable fetch missing both array and buffer fetches externally
// - fetch size from line fill size field and miss offset 3:2
// - line fetch: critical longword first, then wrap modulo 16 bytes
// - recently-used set at miss, cleared by array hit on buffer index
// - at next miss buffer copied only if full and still recently used
// - bit 10: noncacheable fetches use buffer, never copied to array
// - bit 31 clear: cache bypassed, fetches word or longword
// - enabled, bit 10 clear: noncacheable fetches longword, not buffered
// - disabled: longword fetches, word fetch for odd word address
module ic_icache #(
    parameter int AW = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control bus slave
    input wire logic [AW-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [AW-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // instruction fetch from local bus
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_sram,
    output logic fetch_ack,
    output logic fetch_retry,
    output logic [31:0] fetch_data,
    output logic attr_nc,
    output logic attr_bufw,
    output logic attr_wp,
    // line invalidate instruction
    input wire logic linv_req,
    input wire logic [31:0] linv_addr,
    // external bus controller
    output logic ext_req,
    output logic [31:0] ext_addr,
    output ic_pkg::ic_size_t ext_size,
    input wire logic ext_ack,
    input wire logic [31:0] ext_data
);
    import ic_pkg::*;

    function automatic logic ra_match(input logic [31:0] ra, input logic [31:0] a);
        ra_match = ra[`IC_RA_EN] && (((a[31:24] ^ ra[`IC_RA_BASE_HI:`IC_RA_BASE_LO])
            & ~ra[`IC_RA_AMSK_HI:`IC_RA_AMSK_LO]) == 8'h00);
    endfunction

    function automatic logic fill_is_line(input logic [1:0] lfs, input logic [1:0] off);
        if (lfs[1])
            fill_is_line = 1'b1;
        else if (lfs[0])
            fill_is_line = !off[1];
        else
            fill_is_line = (off != 2'h3);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            merge[8*i+:8] = be[i] ? nw[8*i+:8] : old[8*i+:8];
    endfunction

    // arrays, no reset on purpose
    logic [22:0] tag_a [32];
    logic [31:0] tag_v_r;
    logic [31:0] data_mem [128];

    logic [31:0] ccw_r, ra0_r, ra1_r;
    logic inv_busy_r;
    logic [4:0] inv_cnt_r;
    ic_fill_t fill_state_r;
    logic [1:0] fb_ptr_r, beat_cnt_r, fill_last_r;
    logic [27:0] fb_tag_r;
    logic [3:0] fb_vld_r;
    logic [31:0] fb_data_r [4];
    logic fb_open_r, fb_mru_r, fb_nc_r;
    logic aw_have_r, w_have_r;
    logic [AW-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic s_awready_r, s_wready_r, s_bvalid_r, s_arready_r, s_rvalid_r;
    logic [1:0] s_bresp_r, s_rresp_r;
    logic [31:0] s_rdata_r;
    logic fetch_ack_r, fetch_retry_r, attr_nc_r, attr_bufw_r, attr_wp_r;
    logic [31:0] fetch_data_r;
    logic ext_req_r;
    logic [31:0] ext_addr_r;
    ic_size_t ext_size_r;

    // combinational decisions
    logic enb, serve, tag_hit, fb_line, fb_hit, eff_nc, eff_bufw, eff_wp;
    logic start_fill, start_direct, serve_hit, copy_en, wr_fire, wr_ok;
    logic inv_start, linv_go;
    logic [4:0] idx, linv_idx;
    logic [31:0] arr_word;

    always_comb begin
        enb = ccw_r[`IC_CCW_ENB];
        idx = fetch_addr[8:4];
        arr_word = data_mem[fetch_addr[8:2]];
        tag_hit = enb && tag_v_r[idx] && (tag_a[idx] == fetch_addr[31:9]);
        fb_line = enb && fb_open_r && (fb_tag_r == fetch_addr[31:4]);
        fb_hit = fb_line && fb_vld_r[fetch_addr[3:2]];
        // region zero wins over region one, which wins over defaults
        if (ra_match(ra0_r, fetch_addr)) begin
            eff_nc = ra0_r[`IC_RA_NC];
            eff_bufw = ra0_r[`IC_RA_BUFW];
            eff_wp = ra0_r[`IC_RA_WP];
        end else if (ra_match(ra1_r, fetch_addr)) begin
            eff_nc = ra1_r[`IC_RA_NC];
            eff_bufw = ra1_r[`IC_RA_BUFW];
            eff_wp = ra1_r[`IC_RA_WP];
        end else begin
            eff_nc = ccw_r[`IC_CCW_DEF_NC];
            eff_bufw = ccw_r[`IC_CCW_DEF_BUFW];
            eff_wp = ccw_r[`IC_CCW_DEF_WP];
        end
        serve = fetch_req && !fetch_ack_r && !inv_busy_r && !fetch_sram;
        serve_hit = serve && (fb_hit || tag_hit);
        // any miss stalls while a fill is active, else a fresh miss
        start_fill = serve && enb && !fb_hit && !tag_hit && (fill_state_r == FL_IDLE)
            && (!eff_nc || ccw_r[`IC_CCW_NC_BURST]);
        start_direct = serve && (fill_state_r == FL_IDLE)
            && (!enb || (!fb_hit && !tag_hit && eff_nc && !ccw_r[`IC_CCW_NC_BURST]));
        copy_en = start_fill && fb_open_r && (&fb_vld_r) && fb_mru_r && !fb_nc_r;
        wr_fire = aw_have_r && w_have_r && !s_bvalid_r;
        wr_ok = (aw_addr_r == `IC_OFF_CCW) || (aw_addr_r == `IC_OFF_RA0)
            || (aw_addr_r == `IC_OFF_RA1) || (aw_addr_r == `IC_OFF_LINV)
            || (aw_addr_r == `IC_OFF_STAT);
        inv_start = wr_fire && (aw_addr_r == `IC_OFF_CCW) && w_strb_r[3]
            && w_data_r[`IC_CCW_INV];
        // processor port and debug register take the same path
        linv_go = !ccw_r[`IC_CCW_LINV_DIS] && (linv_req
            || (wr_fire && (aw_addr_r == `IC_OFF_LINV)));
        linv_idx = linv_req ? linv_addr[8:4] : w_data_r[8:4];
    end

    // bus write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_awready_r <= 1'b0;
            s_wready_r <= 1'b0;
            s_bvalid_r <= 1'b0;
            s_bresp_r <= 2'h0;
        end else begin
            s_awready_r <= !aw_have_r && !(s_awvalid && s_awready_r);
            s_wready_r <= !w_have_r && !(s_wvalid && s_wready_r);
            if (s_awvalid && s_awready_r) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready_r) begin
                w_have_r <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            if (wr_fire) begin
                s_bvalid_r <= 1'b1;
                s_bresp_r <= wr_ok ? 2'h0 : 2'h2;
            end
            if (s_bvalid_r && s_bready) begin
                s_bvalid_r <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ccw_r <= `IC_CCW_RST;
            ra0_r <= `IC_RA_RST;
            ra1_r <= `IC_RA_RST;
        end else if (wr_fire) begin
            case (aw_addr_r)
                `IC_OFF_CCW: ccw_r <= merge(ccw_r, w_data_r, w_strb_r) & `IC_CCW_MASK;
                `IC_OFF_RA0: ra0_r <= merge(ra0_r, w_data_r, w_strb_r) & `IC_RA_MASK;
                `IC_OFF_RA1: ra1_r <= merge(ra1_r, w_data_r, w_strb_r) & `IC_RA_MASK;
                default: ;
            endcase
        end
    end

    // bus read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready_r <= 1'b0;
            s_rvalid_r <= 1'b0;
            s_rdata_r <= 32'h0000_0000;
            s_rresp_r <= 2'h0;
        end else begin
            s_arready_r <= !s_rvalid_r && !(s_arvalid && s_arready_r);
            if (s_arvalid && s_arready_r) begin
                s_rvalid_r <= 1'b1;
                s_rresp_r <= 2'h0;
                case (s_araddr)
                    `IC_OFF_CCW: s_rdata_r <= ccw_r;
                    `IC_OFF_RA0: s_rdata_r <= ra0_r;
                    `IC_OFF_RA1: s_rdata_r <= ra1_r;
                    `IC_OFF_LINV: s_rdata_r <= 32'h0000_0000;
                    `IC_OFF_STAT: s_rdata_r <= {24'h00_0000, fb_vld_r, fb_nc_r, fb_mru_r,
                        fill_state_r != FL_IDLE, inv_busy_r};
                    default: begin
                        s_rdata_r <= 32'h0000_0000;
                        s_rresp_r <= 2'h2;
                    end
                endcase
            end else if (s_rvalid_r && s_rready) begin
                s_rvalid_r <= 1'b0;
            end
        end
    end

    // whole-cache invalidation sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inv_busy_r <= 1'b0;
            inv_cnt_r <= 5'h00;
        end else if (inv_start && !inv_busy_r) begin
            inv_busy_r <= 1'b1;
            inv_cnt_r <= 5'h00;
        end else if (inv_busy_r) begin
            inv_cnt_r <= inv_cnt_r + 5'h01;
            if (inv_cnt_r == 5'(`IC_INV_CYCLES - 1))
                inv_busy_r <= 1'b0;
        end
    end

    // tag and data arrays, untouched by reset
    always_ff @(posedge aclk) begin
        if (copy_en) begin
            tag_a[fb_tag_r[4:0]] <= fb_tag_r[27:5];
            tag_v_r[fb_tag_r[4:0]] <= 1'b1;
            for (int i = 0; i < 4; i++)
                data_mem[{fb_tag_r[4:0], 2'(i)}] <= fb_data_r[i];
        end
        if (inv_busy_r)
            tag_v_r[inv_cnt_r] <= 1'b0;
        if (linv_go)
            tag_v_r[linv_idx] <= 1'b0;
    end

    // external fetch sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_state_r <= FL_IDLE;
            ext_req_r <= 1'b0;
            ext_addr_r <= 32'h0000_0000;
            ext_size_r <= SZ_LONG;
            beat_cnt_r <= 2'h0;
            fill_last_r <= 2'h0;
            fb_ptr_r <= 2'h0;
        end else begin
            case (fill_state_r)
                FL_IDLE: begin
                    if (start_fill) begin
                        fill_state_r <= FL_LINE;
                        ext_req_r <= 1'b1;
                        ext_addr_r <= {fetch_addr[31:2], 2'h0};
                        fb_ptr_r <= fetch_addr[3:2];
                        beat_cnt_r <= 2'h0;
                        if (fill_is_line(ccw_r[`IC_CCW_LFS_HI:`IC_CCW_LFS_LO],
                                         fetch_addr[3:2])) begin
                            ext_size_r <= SZ_LINE;
                            fill_last_r <= 2'h3;
                        end else begin
                            ext_size_r <= SZ_LONG;
                            fill_last_r <= 2'h0;
                        end
                    end else if (start_direct) begin
                        fill_state_r <= FL_DIRECT;
                        ext_req_r <= 1'b1;
                        if (!enb && fetch_addr[1]) begin
                            ext_size_r <= SZ_WORD;
                            ext_addr_r <= {fetch_addr[31:1], 1'b0};
                        end else begin
                            ext_size_r <= SZ_LONG;
                            ext_addr_r <= {fetch_addr[31:2], 2'h0};
                        end
                    end
                end
                FL_LINE: begin
                    if (ext_ack) begin
                        fb_ptr_r <= fb_ptr_r + 2'h1;
                        beat_cnt_r <= beat_cnt_r + 2'h1;
                        if (beat_cnt_r == fill_last_r) begin
                            fill_state_r <= FL_IDLE;
                            ext_req_r <= 1'b0;
                        end
                    end
                end
                FL_DIRECT: begin
                    if (ext_ack) begin
                        fill_state_r <= FL_IDLE;
                        ext_req_r <= 1'b0;
                    end
                end
                default: begin
                    fill_state_r <= FL_IDLE;
                    ext_req_r <= 1'b0;
                end
            endcase
        end
    end

    // line-fill buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fb_open_r <= 1'b0;
            fb_vld_r <= 4'h0;
            fb_tag_r <= 28'h000_0000;
            fb_mru_r <= 1'b0;
            fb_nc_r <= 1'b0;
            for (int i = 0; i < 4; i++)
                fb_data_r[i] <= 32'h0000_0000;
        end else begin
            if (start_fill) begin
                fb_open_r <= 1'b1;
                fb_vld_r <= 4'h0;
                fb_tag_r <= fetch_addr[31:4];
                fb_mru_r <= 1'b1;
                fb_nc_r <= eff_nc;
            end else begin
                if (fill_state_r == FL_LINE && ext_ack) begin
                    fb_data_r[fb_ptr_r] <= ext_data;
                    fb_vld_r[fb_ptr_r] <= 1'b1;
                end
                if (serve && tag_hit && !fb_hit && (idx == fb_tag_r[4:0]))
                    fb_mru_r <= 1'b0;
            end
            if (inv_start)
                fb_open_r <= 1'b0;
        end
    end

    // fetch answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_ack_r <= 1'b0;
            fetch_retry_r <= 1'b0;
            fetch_data_r <= 32'h0000_0000;
            attr_nc_r <= 1'b0;
            attr_bufw_r <= 1'b0;
            attr_wp_r <= 1'b0;
        end else begin
            fetch_ack_r <= 1'b0;
            fetch_retry_r <= 1'b0;
            if (serve) begin
                attr_nc_r <= eff_nc;
                attr_bufw_r <= eff_bufw;
                attr_wp_r <= eff_wp;
            end
            if (serve_hit) begin
                fetch_ack_r <= 1'b1;
                fetch_data_r <= fb_hit ? fb_data_r[fetch_addr[3:2]] : arr_word;
            end else if (start_fill) begin
                fetch_ack_r <= 1'b1;
                fetch_retry_r <= 1'b1;
            end else if (fill_state_r == FL_DIRECT && ext_ack) begin
                fetch_ack_r <= 1'b1;
                fetch_data_r <= ext_data;
            end
        end
    end

    assign s_awready = s_awready_r;
    assign s_wready = s_wready_r;
    assign s_bvalid = s_bvalid_r;
    assign s_bresp = s_bresp_r;
    assign s_arready = s_arready_r;
    assign s_rvalid = s_rvalid_r;
    assign s_rdata = s_rdata_r;
    assign s_rresp = s_rresp_r;
    assign fetch_ack = fetch_ack_r;
    assign fetch_retry = fetch_retry_r;
    assign fetch_data = fetch_data_r;
    assign attr_nc = attr_nc_r;
    assign attr_bufw = attr_bufw_r;
    assign attr_wp = attr_wp_r;
    assign ext_req = ext_req_r;
    assign ext_addr = ext_addr_r;
    assign ext_size = ext_size_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    inv_length_a: assert property (inv_start && !inv_busy_r
        |=> inv_busy_r && inv_cnt_r == 5'h00 ##31 inv_busy_r && inv_cnt_r == 5'h1f
        ##1 !inv_busy_r)
        else $error("whole invalidation not 32 cycles");
    inv_step_a: assert property (inv_busy_r && inv_cnt_r != 5'h1f
        |=> inv_busy_r && inv_cnt_r == $past(inv_cnt_r) + 5'h01)
        else $error("invalidation counter skipped a step");
    inv_hold_a: assert property (inv_busy_r && fill_state_r == FL_IDLE
        |=> !fetch_ack_r && !ext_req_r)
        else $error("fetch served during invalidation");
    hit_data_a: assert property (serve && tag_hit && !fb_hit
        |=> fetch_ack_r && fetch_data_r == $past(arr_word))
        else $error("array hit not answered next cycle");
    sram_skip_a: assert property (fetch_req && fetch_sram && fill_state_r == FL_IDLE
        |=> !ext_req_r && !fetch_ack_r)
        else $error("external fetch for sram address");
    crit_first_a: assert property (start_fill
        |=> ext_req_r && ext_addr_r[3:2] == $past(fetch_addr[3:2]))
        else $error("critical longword not first");
    fill_size_a: assert property (start_fill && ccw_r[1] |=> ext_size_r == SZ_LINE)
        else $error("line size not chosen");
    bypass_size_a: assert property (start_direct && !enb |=> ext_size_r != SZ_LINE)
        else $error("line fetch while cache disabled");
    nc_long_a: assert property (start_direct && enb
        |=> ext_size_r == SZ_LONG && fill_state_r == FL_DIRECT)
        else $error("noncacheable fetch not longword");
    line_inv_a: assert property (linv_go && !inv_busy_r |=> !tag_v_r[$past(linv_idx)])
        else $error("line invalidate missed");
    mru_set_a: assert property (start_fill |=> fb_mru_r && fb_vld_r == 4'h0)
        else $error("recently-used not set at miss");
    copy_cond_a: assert property (copy_en
        |=> tag_v_r[$past(fb_tag_r[4:0])] || $past(linv_go) || $past(inv_busy_r))
        else $error("buffer copy did not validate line");
    reset_ccw_a: assert property ($rose(aresetn) |-> ccw_r == 32'h0000_0000)
        else $error("control word not cleared by reset");

    line_fill_c: cover property (start_fill ##1 ext_size_r == SZ_LINE);
    buf_hit_c: cover property (serve && fb_hit && fill_state_r == FL_LINE);
    inv_run_c: cover property (inv_busy_r && inv_cnt_r == 5'h1f);
    copy_c: cover property (copy_en);
endmodule // ic_icache

// File: src/ic_defines.svh
`ifndef IC_DEFINES_SVH
`define IC_DEFINES_SVH

// register byte offsets on the control bus
`define IC_OFF_CCW 8'h00
`define IC_OFF_RA0 8'h04
`define IC_OFF_RA1 8'h08
`define IC_OFF_LINV 8'h0c
`define IC_OFF_STAT 8'h10

// cache_control_word fields
`define IC_CCW_ENB 31
`define IC_CCW_LINV_DIS 28
`define IC_CCW_INV 24
`define IC_CCW_NC_BURST 10
`define IC_CCW_DEF_NC 9
`define IC_CCW_DEF_BUFW 8
`define IC_CCW_DEF_WP 5
`define IC_CCW_LFS_HI 1
`define IC_CCW_LFS_LO 0
`define IC_CCW_MASK 32'h9800_0723
`define IC_CCW_RST 32'h0000_0000

// region attribute fields
`define IC_RA_BASE_HI 31
`define IC_RA_BASE_LO 24
`define IC_RA_AMSK_HI 23
`define IC_RA_AMSK_LO 16
`define IC_RA_EN 15
`define IC_RA_NC 6
`define IC_RA_BUFW 5
`define IC_RA_WP 2
`define IC_RA_MASK 32'hffff_e064
`define IC_RA_RST 32'h0000_0000

// timing
`define IC_INV_CYCLES 32

`endif

// File: src/ic_pkg.sv
package ic_pkg;
    typedef enum logic [1:0] {SZ_LONG, SZ_WORD, SZ_LINE} ic_size_t;
    typedef enum logic [1:0] {FL_IDLE, FL_LINE, FL_DIRECT} ic_fill_t;
endpackage

// File: test/ic_ext_model.sv
`timescale 1ns/1ps
module ic_ext_model
    import ic_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus controller side
    input wire logic ext_req,
    input wire logic [31:0] ext_addr,
    input wire ic_pkg::ic_size_t ext_size,
    output logic ext_ack,
    output logic [31:0] ext_data,
    // beat latency
    input wire logic [3:0] lat
);
    import ic_pkg::*;
    logic [31:0] a;
    int n;
    initial begin
        ext_ack = 1'b0;
        ext_data = 32'h0000_0000;
    end
    always begin
        @(posedge aclk);
        if (aresetn === 1'b1 && ext_req === 1'b1) begin
            a = ext_addr;
            n = (ext_size == SZ_LINE) ? 4 : 1;
            for (int i = 0; i < n; i++) begin
                // with no latency ack stays high between beats
                if (lat != 4'h0) begin
                    ext_ack <= 1'b0;
                    repeat (lat) @(posedge aclk);
                end
                ext_ack <= 1'b1;
                ext_data <= ~{a[31:4], a[3:2] + 2'(i), 2'b00};
                @(posedge aclk);
            end
            ext_ack <= 1'b0;
            // released data does not linger
            ext_data <= ~ext_data;
        end
    end
endmodule // ic_ext_model

// File: test/ic_icache_tb_top.sv
`timescale 1ns/1ps
module ic_icache_tb_top;
    import ic_pkg::*;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready;
    logic s_wready, s_bvalid, s_arready, s_rvalid, fetch_req, fetch_sram, fetch_ack, fetch_retry;
    logic attr_nc, attr_bufw, attr_wp, linv_req, ext_req, ext_ack, req_q, rt;
    logic [7:0] s_awaddr, s_araddr;
    logic [3:0] s_wstrb, lat;
    logic [1:0] s_bresp, s_rresp, sz_seen, r2;
    logic [31:0] s_wdata, s_rdata, fetch_addr, fetch_data, linv_addr, ext_addr, ext_data;
    logic [31:0] d, ad_seen;
    ic_size_t ext_size;
    int fails, n_compared, n, beats, nreq, e, k_req;

    ic_icache #(.AW(8)) dut (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .fetch_req, .fetch_addr, .fetch_sram,
        .fetch_ack, .fetch_retry, .fetch_data, .attr_nc, .attr_bufw, .attr_wp, .linv_req,
        .linv_addr, .ext_req, .ext_addr, .ext_size, .ext_ack, .ext_data
    );
    ic_ext_model ext_bus (.aclk, .aresetn, .ext_req, .ext_addr, .ext_size, .ext_ack, .ext_data, .lat);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // external request monitor
    always @(posedge aclk) begin
        req_q <= ext_req;
        if (ext_req === 1'b1 && req_q !== 1'b1) begin
            sz_seen <= ext_size;
            ad_seen <= ext_addr;
            beats <= 0;
            nreq <= nreq + 1;
        end else if (ext_ack === 1'b1) begin
            beats <= beats + 1;
        end
    end

    function automatic logic [31:0] edat(input logic [31:0] a);
        return ~{a[31:2], 2'b00};
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            fails++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        r2 = s_bresp;
        s_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        d = s_rdata;
        r2 = s_rresp;
        s_rready <= 1'b0;
    endtask

    // ert: 0 data, 1 retry, 2 no retry, 3 nothing checked
    task automatic fx(input logic [31:0] a, input logic [1:0] ert);
        @(posedge aclk);
        fetch_addr <= a;
        fetch_req <= 1'b1;
        for (n = 1; n < 300; n++) begin
            @(posedge aclk);
            if (fetch_ack === 1'b1) break;
        end
        fetch_req <= 1'b0;
        rt = fetch_retry;
        d = fetch_data;
        if (ert != 2'b11) chk(32'({n < 300, rt}), 32'({1'b1, ert == 2'b01}));
        if (ert == 2'b00) chk(d, edat(a));
    endtask

    task automatic settle();
        for (int k = 0; k < 300 && ext_req !== 1'b0; k++) @(posedge aclk);
        repeat (2) @(posedge aclk);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        test_done();
    end

    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, fetch_req, fetch_sram} = '0;
        {s_awaddr, s_araddr, s_wdata, fetch_addr, linv_addr, linv_req, lat} = '0;
        s_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(8'h00);
        chk(d, 32'h0000_0000);
        rd(8'h24);
        chk(32'(r2), 32'h0000_0002);
        wr(8'h24, 32'h0000_0000);
        chk(32'(r2), 32'h0000_0002);
        wr(8'h00, 32'h0100_0000);
        fx(32'h1000_0000, 2'b00);
        chk(32'(n >= 28), 32'h0000_0001);
        settle();
        chk(32'(sz_seen), 32'(SZ_LONG));
        wr(8'h00, 32'h0000_0402);
        fx(32'h3000_0002, 2'b10);
        settle();
        chk(32'(sz_seen), 32'(SZ_WORD));
        $display("test reset and bypass done");
        wr(8'h00, 32'h8000_0002);
        lat <= 4'h3;
        fx(32'h1000_0024, 2'b01);
        @(posedge aclk);
        chk(32'(sz_seen), 32'(SZ_LINE));
        chk(ad_seen, 32'h1000_0024);
        for (int i = 1; i < 5; i++) fx(32'h1000_0020 + 32'((i % 4) * 4), 2'b00);
        settle();
        chk(32'(beats), 32'h0000_0004);
        rd(8'h10);
        chk(d, 32'h0000_00f4);
        lat <= 4'h0;
        fx(32'h1000_0040, 2'b01);
        settle();
        fx(32'h1000_0028, 2'b00);
        chk(32'(n), 32'h0000_0002);
        @(posedge aclk);
        linv_addr <= 32'h0000_0020;
        linv_req <= 1'b1;
        @(posedge aclk);
        linv_req <= 1'b0;
        fx(32'h1000_0028, 2'b01);
        settle();
        $display("test line fill done");
        for (int f = 0; f < 4; f++) begin
            for (int o = 0; o < 4; o++) begin
                wr(8'h00, 32'h8000_0000 | 32'(f));
                fx(32'h2000_0000 + 32'((f * 4 + o) * 16 + o * 4), 2'b11);
                settle();
                e = (f > 1 || o < 2 || (f == 0 && o == 2)) ? 4 : 1;
                chk(32'(beats), 32'(e));
                chk(32'(sz_seen), e == 4 ? 32'(SZ_LINE) : 32'(SZ_LONG));
            end
        end
        $display("test fill size done");
        wr(8'h04, 32'h4000_8044);
        wr(8'h08, 32'h40ff_8020);
        wr(8'h00, 32'h8000_0002);
        fx(32'h4000_0100, 2'b00);
        settle();
        chk(32'(sz_seen), 32'(SZ_LONG));
        chk(32'({attr_nc, attr_bufw, attr_wp}), 32'h0000_0005);
        fx(32'h5000_0100, 2'b01);
        settle();
        chk(32'({attr_nc, attr_bufw, attr_wp}), 32'h0000_0002);
        wr(8'h00, 32'h8000_0402);
        fx(32'h4000_0200, 2'b01);
        settle();
        chk(32'(sz_seen), 32'(SZ_LINE));
        fx(32'h4000_0204, 2'b00);
        k_req = nreq;
        fetch_sram <= 1'b1;
        fx(32'h6000_0000, 2'b11);
        fetch_sram <= 1'b0;
        chk(32'(n), 32'h0000_012c);
        chk(32'(nreq), 32'(k_req));
        $display("test regions and sram done");
        test_done();
    end
endmodule // ic_icache_tb_top
